// ### common/vtr_pkg.sv
// package for the virtual interrupt feature report register
// assumes a core clock domain and a system register read port from the decoder
`default_nettype none
package vtr_pkg;
  // system register encoding of the feature report register
  localparam logic [1:0] VTR_OP0 = 2'h3;
  localparam logic [2:0] VTR_OP1 = 3'h4;
  localparam logic [3:0] VTR_CRN = 4'hc;
  localparam logic [3:0] VTR_CRM = 4'hb;
  localparam logic [2:0] VTR_OP2 = 3'h1;
  // field values
  localparam logic [2:0] VTR_PRI_VAL = 3'h4;
  localparam logic [2:0] VTR_PRE_VAL = 3'h4;
  localparam logic [2:0] VTR_PRE_MAX = 3'h6;
  localparam logic [2:0] VTR_ID_VAL = 3'h0;
  localparam logic VTR_SYSTEM_ERROR_IRQ_SUPPORT_VAL = 1'h0;
  localparam logic VTR_A3V_VAL = 1'h1;
  localparam logic VTR_NV4_VAL = 1'h0;
  localparam logic VTR_TDS_VAL = 1'h1;
  localparam logic [4:0] VTR_LR_VAL = 5'h03;
  localparam logic [5:0] VTR_TRAP_CLASS = 6'h18;
  localparam logic [63:0] VTR_RESET_DATA = 64'h0;
  // exception levels
  localparam logic [1:0] VTR_EL0 = 2'h0;
  localparam logic [1:0] VTR_EL1 = 2'h1;
  localparam logic [1:0] VTR_EL2 = 2'h2;
  localparam logic [1:0] VTR_EL3 = 2'h3;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } vtr_enc_t;

  typedef struct packed {
    logic [31:0] reserved_hi;
    logic [2:0] priority_width_minus_one;
    logic [2:0] preemption_width_minus_one;
    logic [2:0] identifier_width_code;
    logic system_error_irq_support;
    logic affinity3_valid;
    logic direct_injection_absent;
    logic separate_deactivate_trap_support;
    logic [13:0] reserved_lo;
    logic [4:0] list_register_count_minus_one;
  } vtr_report_t;

  typedef struct packed {
    logic done;
    logic undefined;
    logic trap;
    logic [5:0] trap_class;
    logic [63:0] data;
  } vtr_resp_t;
endpackage
`default_nettype wire

// ### logic/vtr_feature_report.sv
// read-only virtual interrupt feature report register with privilege checks
// assumes the instruction decoder presents a one-cycle read request on clk
`default_nettype none
// Overview of operation
// - priority width field reads 100
// - priority field matches interface control copy
// - preemption width field reads 100
// - preemption field within priority field, max 6
// - preemption field sets binary point floor
// - identifier width code reads 000
// - system error support bit reads zero
// - affinity3 valid bit reads one
// - direct injection absent bit reads zero
// - separate deactivate trap bit reads one
// - list register count field reads 00011
// - application level read is undefined
// - kernel read traps class 0x18 or undefined
// - hypervisor and monitor reads return contents
// - no hypervisor level: zeros, absent bit one
module vtr_feature_report (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire vtr_pkg::vtr_enc_t rd_enc,
  input wire logic [1:0] cur_el,
  input wire logic el2_enabled,
  input wire logic nested_virtualization_enable,
  input wire logic el2_implemented,
  output logic hit,
  output vtr_pkg::vtr_resp_t resp,
  output logic [2:0] priority_width_minus_one,
  output logic [2:0] min_virtual_group0_binary_point
);
  import vtr_pkg::*;

  // one-hot answer shape of an access; one code per kind of reply
  typedef enum logic [4:0] {
    VTR_OUT_NONE = 5'h01,
    VTR_OUT_UNDEF = 5'h02,
    VTR_OUT_TRAP = 5'h04,
    VTR_OUT_FULL = 5'h08,
    VTR_OUT_BARE = 5'h10
  } vtr_outcome_t;

  vtr_report_t field_view;
  vtr_report_t used_mask;
  vtr_report_t bare_view;
  wire [63:0] full_bits;
  wire [4:0] enc_match;
  logic [2:0] preemption_value;
  logic taken;
  logic kernel_trap;
  vtr_outcome_t outcome;
  vtr_resp_t resp_reg;
  vtr_resp_t resp_next;
  logic [2:0] pri_alias_reg;
  logic [2:0] pri_alias_next;
  logic [2:0] bp_floor_reg;
  logic [2:0] bp_floor_next;

  // clamp only matters if the constants are ever edited into a bad pair
  always_comb begin
    if (VTR_PRE_VAL > VTR_PRI_VAL) begin
      preemption_value = VTR_PRI_VAL;
    end else begin
      preemption_value = VTR_PRE_VAL;
    end
    if (preemption_value > VTR_PRE_MAX) begin
      preemption_value = VTR_PRE_MAX;
    end
  end

  // fields are constants with no storage, so no write can alter them
  always_comb begin
    field_view = '0;
    field_view.priority_width_minus_one = VTR_PRI_VAL;
    field_view.preemption_width_minus_one = preemption_value;
    field_view.identifier_width_code = VTR_ID_VAL;
    field_view.system_error_irq_support = VTR_SYSTEM_ERROR_IRQ_SUPPORT_VAL;
    field_view.affinity3_valid = VTR_A3V_VAL;
    field_view.direct_injection_absent = VTR_NV4_VAL;
    field_view.separate_deactivate_trap_support = VTR_TDS_VAL;
    field_view.list_register_count_minus_one = VTR_LR_VAL;
  end

  // marks the defined fields; every other bit is reserved
  always_comb begin
    used_mask = '0;
    used_mask.priority_width_minus_one = '1;
    used_mask.preemption_width_minus_one = '1;
    used_mask.identifier_width_code = '1;
    used_mask.system_error_irq_support = 1'b1;
    used_mask.affinity3_valid = 1'b1;
    used_mask.direct_injection_absent = 1'b1;
    used_mask.separate_deactivate_trap_support = 1'b1;
    used_mask.list_register_count_minus_one = '1;
  end

  // without a hypervisor level only the absent flag reads one
  always_comb begin
    bare_view = '0;
    bare_view.direct_injection_absent = 1'b1;
  end

  // a field that slips into a reserved range is masked off bit by bit
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < $bits(vtr_report_t); bit_idx = bit_idx + 1) begin : g_mask
      assign full_bits[bit_idx] = field_view[bit_idx] & used_mask[bit_idx];
    end
  endgenerate

  // copies for the interface control register and the binary point floor;
  // registered so both views agree from the first edge after reset
  always_comb begin
    pri_alias_next = field_view.priority_width_minus_one;
    bp_floor_next = preemption_value;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pri_alias_reg <= VTR_PRI_VAL;
      bp_floor_reg <= preemption_value;
    end else if (clk_en) begin
      pri_alias_reg <= pri_alias_next;
      bp_floor_reg <= bp_floor_next;
    end
  end

  assign priority_width_minus_one = pri_alias_reg;
  assign min_virtual_group0_binary_point = bp_floor_reg;

  // each encoding field is compared on its own, then all must agree
  assign enc_match[0] = rd_enc.op0 == VTR_OP0;
  assign enc_match[1] = rd_enc.op1 == VTR_OP1;
  assign enc_match[2] = rd_enc.crn == VTR_CRN;
  assign enc_match[3] = rd_enc.crm == VTR_CRM;
  assign enc_match[4] = rd_enc.op2 == VTR_OP2;
  assign hit = &enc_match;

  // writes to this encoding are served elsewhere; nothing here is stored
  assign taken = rd_req && hit && !wr_req;
  assign kernel_trap = el2_enabled && nested_virtualization_enable;

  // privilege decides the answer shape before any data is chosen
  always_comb begin
    outcome = VTR_OUT_NONE;
    if (taken) begin
      case (cur_el)
        VTR_EL0: begin
          outcome = VTR_OUT_UNDEF;
        end
        VTR_EL1: begin
          if (kernel_trap) begin
            outcome = VTR_OUT_TRAP;
          end else begin
            outcome = VTR_OUT_UNDEF;
          end
        end
        VTR_EL2: begin
          outcome = VTR_OUT_FULL;
        end
        VTR_EL3: begin
          if (el2_implemented) begin
            outcome = VTR_OUT_FULL;
          end else begin
            outcome = VTR_OUT_BARE;
          end
        end
        default: begin
          outcome = VTR_OUT_UNDEF;
        end
      endcase
    end
  end

  // every field of the reply is spelled out per shape, so none leaks across
  always_comb begin
    resp_next = '0;
    case (outcome)
      VTR_OUT_UNDEF: begin
        resp_next.done = 1'b1;
        resp_next.undefined = 1'b1;
        resp_next.trap = 1'b0;
        resp_next.trap_class = '0;
        resp_next.data = '0;
      end
      VTR_OUT_TRAP: begin
        resp_next.done = 1'b1;
        resp_next.undefined = 1'b0;
        resp_next.trap = 1'b1;
        resp_next.trap_class = VTR_TRAP_CLASS;
        resp_next.data = '0;
      end
      VTR_OUT_FULL: begin
        resp_next.done = 1'b1;
        resp_next.undefined = 1'b0;
        resp_next.trap = 1'b0;
        resp_next.trap_class = '0;
        resp_next.data = full_bits;
      end
      VTR_OUT_BARE: begin
        resp_next.done = 1'b1;
        resp_next.undefined = 1'b0;
        resp_next.trap = 1'b0;
        resp_next.trap_class = '0;
        resp_next.data = bare_view;
      end
      default: begin
        resp_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resp_reg <= '0;
    end else if (clk_en) begin
      resp_reg <= resp_next;
    end
  end

  assign resp = resp_reg;
endmodule
`default_nettype wire

// ### bench/vtr_feature_report_assertions.sv
// timing checks on the feature report register ports
// assumes one clock and a synchronous active-high reset
`default_nettype none
module vtr_feature_report_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire vtr_pkg::vtr_enc_t rd_enc,
  input wire logic [1:0] cur_el,
  input wire logic el2_enabled,
  input wire logic nested_virtualization_enable,
  input wire logic el2_implemented,
  input wire logic hit,
  input wire vtr_pkg::vtr_resp_t resp
);
  import vtr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // decoded here, not from hit, so a bad decoder cannot hide itself
  wire tk = clk_en && rd_req && !wr_req && rd_enc == 16'he659;
  wire nv_trap = el2_enabled && nested_virtualization_enable;
  a_hit_decode: assert property (hit == (rd_enc == 16'he659))
    else $error("hit decode wrong");
  a_report_value: assert property (tk && cur_el[1] && el2_implemented |=>
    resp.done && resp.data == 64'h90280003) else $error("report value wrong");
  a_pre_bound: assert property (resp.done && resp.data[28:26] != 3'h0 |->
    resp.data[28:26] <= resp.data[31:29] && resp.data[28:26] <= 3'h6)
    else $error("preemption above priority");
  a_el1_trap: assert property (tk && cur_el == 2'h1 && nv_trap |=>
    resp.trap && resp.trap_class == 6'h18) else $error("kernel read did not trap");
  a_read_undef: assert property (tk && (cur_el == 2'h0 || cur_el == 2'h1 && !nv_trap) |=>
    resp.undefined && !resp.trap) else $error("read not undefined");
  a_no_el2: assert property (tk && cur_el == 2'h3 && !el2_implemented |=>
    resp.data == 64'h100000) else $error("monitor read without hypervisor wrong");
  a_refused_zero: assert property (clk_en && !tk |=> resp == '0)
    else $error("refused access answered");
  a_hold_frozen: assert property (!clk_en |=> $stable(resp)) else $error("resp moved");
endmodule
bind vtr_feature_report vtr_feature_report_assertions u_chk (
  .clk(clk),
  .rst(rst),
  .clk_en(clk_en),
  .rd_req(rd_req),
  .wr_req(wr_req),
  .rd_enc(rd_enc),
  .cur_el(cur_el),
  .el2_enabled(el2_enabled),
  .nested_virtualization_enable(nested_virtualization_enable),
  .el2_implemented(el2_implemented),
  .hit(hit),
  .resp(resp)
);
`default_nettype wire

// ### bench/tb_vtr_feature_report.sv
// random self-checking bench for the feature report register
// assumes the dut answers one enabled edge after the request
`default_nettype none
module tb_vtr_feature_report;
  timeunit 1ns;
  timeprecision 1ps;
  import vtr_pkg::*;
  logic clk = 0, rst = 1, clk_en = 0, rd_req = 0, wr_req = 0, el2_enabled = 0;
  logic nested_virtualization_enable = 0, el2_implemented = 1, hit;
  logic [1:0] cur_el = 0;
  logic [2:0] priority_width_minus_one, min_virtual_group0_binary_point;
  vtr_enc_t rd_enc = '0;
  vtr_resp_t resp, exp_resp;
  int n_mismatch = 0, cmp_count = 0, seed = 62;
  vtr_feature_report u_dut (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .rd_req(rd_req),
    .wr_req(wr_req),
    .rd_enc(rd_enc),
    .cur_el(cur_el),
    .el2_enabled(el2_enabled),
    .nested_virtualization_enable(nested_virtualization_enable),
    .el2_implemented(el2_implemented),
    .hit(hit),
    .resp(resp),
    .priority_width_minus_one(priority_width_minus_one),
    .min_virtual_group0_binary_point(min_virtual_group0_binary_point)
  );
  function automatic vtr_resp_t expect_f();
    vtr_resp_t r = '0;
    if (rd_req && !wr_req && rd_enc == 16'he659) begin
      r.done = 1'b1;
      r.trap = cur_el == 2'h1 && el2_enabled && nested_virtualization_enable;
      r.trap_class = r.trap ? 6'h18 : 6'h00;
      r.undefined = !cur_el[1] && !r.trap;
      if (cur_el[1])
        r.data = (cur_el == 2'h3 && !el2_implemented) ? 64'h100000 : 64'h90280003;
    end
    return r;
  endfunction
  task automatic check(input string name, input logic [72:0] seen, input logic [72:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  // reference register: frozen when clk_en is low, like the dut
  always @(posedge clk) if (rst) exp_resp <= '0; else if (clk_en) exp_resp <= expect_f();
  always @(negedge clk) begin
    if (!rst) begin
      check("resp", resp, exp_resp);
      check("pri", priority_width_minus_one, 3'h4);
      check("bp", min_virtual_group0_binary_point, 3'h4);
      check("hit", hit, rd_enc == 16'he659);
    end
  end
  initial begin
    #(2000 * 25);
    n_mismatch++;
    test_done();
  end
  initial begin
    logic [1:0] el;
    logic imp;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // corners: every level and control mix, one write, one near miss, one frozen edge
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      cur_el <= 2'(i);
      el2_implemented <= i[2] || i[1:0] == 2'h2;
      el2_enabled <= i[3];
      nested_virtualization_enable <= i[4];
      clk_en <= i != 40;
      rd_req <= 1'b1;
      wr_req <= i == 21;
      rd_enc <= (i == 50) ? 16'he658 : 16'he659;
    end
    repeat (1200) begin
      @(posedge clk);
      el = 2'($random(seed));
      imp = ($random(seed) & 3) != 0;
      if (!imp && el == 2'h2) el = 2'h3;
      cur_el <= el;
      el2_implemented <= imp;
      clk_en <= ($random(seed) & 7) != 0;
      rd_req <= 1'($random(seed));
      wr_req <= ($random(seed) & 7) == 0;
      el2_enabled <= 1'($random(seed));
      nested_virtualization_enable <= 1'($random(seed));
      rd_enc <= ($random(seed) & 3) ? 16'he659 : 16'($random(seed));
    end
    test_done();
  end
endmodule
`default_nettype wire
